/* mfs_ctrl.sv */
// Controller for a three-phase power stage: drives clears and PWM, reads status pins.
// Assumes status pins are synchronous and already resolved to logic levels.
//
// Summary of operation
// R01: The device holds outputs in high impedance until its supplies pass undervoltage; nothing to do here.
// R02: Keep all three clears low while the system powers up so bootstrap caps charge.
// R03: Keep all three clears low while the system powers down; in MFS_LATCHED a same-cycle fault release delays the drop by one cycle.
// R04: Fault and warning arrive as active-low open-drain lines pulled up in the device.
// R05: A low fault line means the device has shut down.
// R06: A low warning line means the junction is above the warning level.
// R07: The fault and warning pair decode to warn+shutdown, shutdown, warn or normal.
// R08: On a fault the device drops its outputs; the controller stops PWM too.
// R09: Non-latching faults recover alone, so the controller waits unless i_recover asks for a latch clear.
// R10: After a latched shutdown no clear is issued before one second has passed; a power or enable cycle through MFS_HOLD releases the clears at once.
// R11: The device recharges bootstrap caps by itself when they run low.
// R12: Too high a duty cycle may trigger recharge, so the duty is limited.
// R13: Every PWM cycle keeps the low side on for at least 50 ns.
// R14: While the warning is low the controller asks the load to be reduced.
// R15: A rising edge on a clear releases that bridge; thermal shutdown needs all three.
// R16: A low clear forces that bridge to high impedance, so PWM is held off meanwhile.
`timescale 1ns/1ps
`default_nettype none
module mfs_ctrl #(
  parameter int unsigned HOLDOFF_CYC = mfs_pkg::CLEAR_HOLDOFF_CYC
) (
  input wire logic i_clk, // System clock, 40 MHz
  input wire logic i_rst, // Async reset, high
  input wire logic i_power_good, // System supplies up and stable
  input wire logic i_enable, // Run request from the user
  input wire logic i_recover, // Request to clear a latched shutdown
  input wire logic [mfs_pkg::N_BRIDGE-1:0] i_pwm, // Raw PWM requests per bridge
  input wire logic i_fault_n, // Device fault line, low active
  input wire logic i_thermal_warning_n, // Device warning line, low active
  output logic [mfs_pkg::N_BRIDGE-1:0] o_pwm, // PWM to the device
  output logic [mfs_pkg::N_BRIDGE-1:0] o_clear_n, // Bridge clears, low holds Hi-Z
  output mfs_pkg::mfs_status_t o_status, // Decoded status pair
  output logic o_reduce_load, // Ask to lower the load current
  output logic o_running // Bridges released and PWM active
);
  import mfs_pkg::*;

  typedef enum logic [2:0] {
    MFS_HOLD, MFS_RUN, MFS_WAIT_AUTO, MFS_HOLDOFF, MFS_LATCHED, MFS_CLEAR_PULSE
  } mfs_state_t;

  localparam int unsigned HW = $clog2(HOLDOFF_CYC + 1);

  mfs_state_t state_q, state_d;
  logic [HW-1:0] hold_cnt_q, hold_cnt_d;
  logic [2:0] pulse_cnt_q, pulse_cnt_d;
  logic [N_BRIDGE-1:0] clear_n_q, clear_n_d;
  logic [N_BRIDGE-1:0] gate_q, gate_d;
  mfs_status_t status_q, status_d;
  logic reduce_q, reduce_d;
  logic running_q, running_d;
  logic [N_BRIDGE-1:0] shaped;

  function automatic mfs_status_t decode_status(input logic fault_n, input logic warn_n);
    decode_status = mfs_status_t'({fault_n, warn_n}); // R07
  endfunction

  genvar g;
  generate
    for (g = 0; g < N_BRIDGE; g++) begin : g_shape
      mfs_pwm_shaper #(
        .MIN_LOW(LS_MIN_ON_CYC)
      ) u_shape (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_pwm(i_pwm[g]),
        .o_pwm(shaped[g]) // R12
      );
    end
  endgenerate

  always_comb begin
    state_d = state_q;
    hold_cnt_d = hold_cnt_q;
    pulse_cnt_d = pulse_cnt_q;
    clear_n_d = clear_n_q;
    status_d = decode_status(i_fault_n, i_thermal_warning_n); // R04 R06
    reduce_d = !i_thermal_warning_n; // R14
    unique case (state_q)
      MFS_HOLD: begin
        clear_n_d = CLEAR_ALL_LOW; // R02 R03
        if (i_power_good && i_enable) begin
          clear_n_d = CLEAR_ALL_HIGH; // R15
          state_d = MFS_RUN;
        end
      end
      MFS_RUN: begin
        if (!i_power_good || !i_enable) begin
          clear_n_d = CLEAR_ALL_LOW; // R03
          state_d = MFS_HOLD;
        end else if (!i_fault_n) begin
          // Warning with fault means thermal or overcurrent latch
          hold_cnt_d = '0;
          state_d = (i_thermal_warning_n && !i_recover) ? MFS_WAIT_AUTO : MFS_HOLDOFF; // R05 R08
        end
      end
      MFS_WAIT_AUTO: begin
        // Supply faults clear on their own; a request asks for a latch clear instead
        if (!i_power_good || !i_enable) begin
          clear_n_d = CLEAR_ALL_LOW;
          state_d = MFS_HOLD;
        end else if (i_fault_n) begin
          state_d = MFS_RUN; // R09
        end else if (i_recover) begin
          state_d = MFS_HOLDOFF;
        end else if (hold_cnt_q != HW'(HOLDOFF_CYC)) begin
          hold_cnt_d = hold_cnt_q + HW'(1);
        end
      end
      MFS_HOLDOFF: begin
        // Supplies going away must drop the clears even mid hold-off
        if (!i_power_good || !i_enable) begin
          clear_n_d = CLEAR_ALL_LOW; // R03
          state_d = MFS_HOLD;
        end else if (i_fault_n) begin
          state_d = MFS_RUN;
        end else if (hold_cnt_q >= HW'(HOLDOFF_CYC)) begin // R10
          state_d = MFS_LATCHED;
        end else begin
          hold_cnt_d = hold_cnt_q + HW'(1);
        end
      end
      MFS_LATCHED: begin
        if (i_fault_n) begin
          state_d = MFS_RUN;
        end else if (i_recover && i_power_good && i_enable) begin
          // All three pulsed so a thermal latch clears as well
          clear_n_d = CLEAR_ALL_LOW; // R15 R16
          pulse_cnt_d = '0;
          state_d = MFS_CLEAR_PULSE;
        end else if (!i_power_good || !i_enable) begin
          clear_n_d = CLEAR_ALL_LOW;
          state_d = MFS_HOLD;
        end
      end
      MFS_CLEAR_PULSE: begin
        if (!i_power_good || !i_enable) begin
          clear_n_d = CLEAR_ALL_LOW; // R03
          state_d = MFS_HOLD;
        end else if (pulse_cnt_q == 3'(CLEAR_LOW_CYC - 1)) begin
          clear_n_d = CLEAR_ALL_HIGH; // R15
          hold_cnt_d = '0;
          state_d = MFS_RUN;
        end else begin
          pulse_cnt_d = pulse_cnt_q + 3'h1;
        end
      end
      default: begin
        clear_n_d = CLEAR_ALL_LOW;
        state_d = MFS_HOLD;
      end
    endcase
  end

  // PWM only while released and no fault; device is Hi-Z otherwise anyway
  always_comb begin
    running_d = (state_d == MFS_RUN) && i_fault_n; // R01 R11
    gate_d = running_d ? (shaped & clear_n_d) : '0; // R08 R16
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= MFS_HOLD;
      hold_cnt_q <= '0;
      pulse_cnt_q <= 3'h0;
      clear_n_q <= CLEAR_ALL_LOW;
      gate_q <= '0;
      status_q <= MFS_ST_NORMAL;
      reduce_q <= 1'b0;
      running_q <= 1'b0;
    end else begin
      state_q <= state_d;
      hold_cnt_q <= hold_cnt_d;
      pulse_cnt_q <= pulse_cnt_d;
      clear_n_q <= clear_n_d;
      gate_q <= gate_d;
      status_q <= status_d;
      reduce_q <= reduce_d;
      running_q <= running_d;
    end
  end

  assign o_pwm = gate_q;
  assign o_clear_n = clear_n_q;
  assign o_status = status_q;
  assign o_reduce_load = reduce_q;
  assign o_running = running_q;
endmodule
`default_nettype wire

/* mfs_ctrl_props.sv */
// Concurrent checks on the controller ports.
// Assumes the bind below and one clock domain.
`timescale 1ns/1ps
`default_nettype none
module mfs_ctrl_props #(
  parameter int unsigned HOLDOFF_CYC = 20
) (
  input wire logic i_clk, i_rst, i_power_good, i_recover, i_fault_n, i_thermal_warning_n,
  input wire logic [mfs_pkg::N_BRIDGE-1:0] o_pwm,
  input wire logic [mfs_pkg::N_BRIDGE-1:0] o_clear_n,
  input wire mfs_pkg::mfs_status_t o_status,
  input wire logic o_reduce_load, o_running
);
  import mfs_pkg::*;
  int unsigned low_q;
  int unsigned low_d;
  always_comb low_d = i_fault_n ? 0 : low_q + 1;
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) low_q <= 0;
    else low_q <= low_d;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  chk_status_pair: assert property (!$past(i_rst) |-> o_status == {$past(i_fault_n), $past(i_thermal_warning_n)})
    else $error("status pair decode wrong");
  chk_reduce_load: assert property (!$past(i_rst) |-> o_reduce_load == !$past(i_thermal_warning_n))
    else $error("reduce load wrong");
  chk_fault_stop: assert property (!i_fault_n |=> !o_running && o_pwm == 3'h0)
    else $error("pwm kept after fault");
  chk_power_hold: assert property (!i_power_good |=> o_clear_n == 3'h0)
    else $error("clears not held low");
  chk_clears_move: assert property (o_clear_n == 3'h0 || o_clear_n == 3'h7)
    else $error("clears split");
  chk_clear_quiet: assert property (o_clear_n != 3'h7 |-> o_pwm == 3'h0 && !o_running)
    else $error("pwm while cleared");
  chk_holdoff_wait: assert property ($rose(o_clear_n[0]) && !i_fault_n |-> low_q >= HOLDOFF_CYC)
    else $error("clear too early");
  chk_clear_pulse: assert property ($fell(o_clear_n[0]) && !i_fault_n |-> (o_clear_n == 3'h0)[*4] ##1 o_clear_n == 3'h7)
    else $error("clear pulse width wrong");
  chk_low_phase: assert property (o_running && $past(o_running) && $fell(o_pwm[0]) |=> !o_pwm[0] || !o_running)
    else $error("low phase too short");
endmodule
bind mfs_ctrl mfs_ctrl_props #(.HOLDOFF_CYC(HOLDOFF_CYC)) mfs_ctrl_props_i (.i_clk(i_clk), .i_rst(i_rst),
  .i_power_good(i_power_good), .i_recover(i_recover), .i_fault_n(i_fault_n), .i_thermal_warning_n(i_thermal_warning_n),
  .o_pwm(o_pwm), .o_clear_n(o_clear_n), .o_status(o_status), .o_reduce_load(o_reduce_load), .o_running(o_running));
`default_nettype wire

/* mfs_dev_model.sv */
// Behavioural power stage: latches overcurrent and thermal shutdowns, pulls the status lines.
// Assumes the bench resolves the open-drain lines with pull-ups.
`timescale 1ns/1ps
`default_nettype none
module mfs_dev_model (
  input wire logic i_clk, // Sampling clock for latches
  input wire logic [2:0] i_clear_n, // Bridge clears
  input wire logic i_uv, // Supply undervoltage
  input wire logic i_oc, // Overcurrent event
  input wire logic i_hot, // Junction above shutdown level
  input wire logic i_warm, // Junction above warning level
  output logic o_fault_pull, // Pulls fault line low
  output logic o_warn_pull, // Pulls warning line low
  output logic o_hiz // Bridge outputs floating
);
  logic oc_q = 1'b0;
  logic ot_q = 1'b0;
  logic [2:0] prev_q = 3'h0;
  logic [2:0] seen_q = 3'h0;
  logic [2:0] rise;
  assign rise = i_clear_n & ~prev_q;
  always @(posedge i_clk) begin
    prev_q <= i_clear_n;
    if (i_oc) oc_q <= 1'b1;
    else if (|rise) oc_q <= 1'b0;
    // Thermal latch needs a rise on every bridge
    if (i_hot) begin
      ot_q <= 1'b1;
      seen_q <= 3'h0;
    end else begin
      seen_q <= seen_q | rise;
      if (&(seen_q | rise)) ot_q <= 1'b0;
    end
  end
  assign o_fault_pull = i_uv | oc_q | ot_q;
  assign o_warn_pull = i_warm;
  assign o_hiz = o_fault_pull | ~&i_clear_n;
endmodule
`default_nettype wire

/* mfs_pkg.sv */
// Constants shared by the motor stage fault supervisor controller.
// Assumes a 40 MHz system clock.
package mfs_pkg;
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned CLK_PERIOD_PS = 25_000;
  localparam int unsigned N_BRIDGE = 3;
  // Hold-off before an external clear after a latched shutdown
  localparam int unsigned CLEAR_HOLDOFF_MS = 1000;
  localparam int unsigned CLEAR_HOLDOFF_CYC = CLEAR_HOLDOFF_MS * (CLK_HZ / 1000);
  // Least low-side on time per PWM cycle
  localparam int unsigned LS_MIN_ON_NS = 50;
  localparam int unsigned LS_MIN_ON_CYC = (LS_MIN_ON_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  // Width of the clear pulse that gives the rising edge
  localparam int unsigned CLEAR_LOW_CYC = 4;
  // Status decode of the fault and warning pair
  typedef enum logic [1:0] {
    MFS_ST_WARN_SHUTDOWN = 2'h0,
    MFS_ST_SHUTDOWN = 2'h1,
    MFS_ST_WARN = 2'h2,
    MFS_ST_NORMAL = 2'h3
  } mfs_status_t;
  localparam logic [2:0] CLEAR_ALL_LOW = 3'h0;
  localparam logic [2:0] CLEAR_ALL_HIGH = 3'h7;
endpackage

/* mfs_pwm_shaper.sv */
// One half-bridge PWM shaper: stretches the low phase to the least on time.
// Assumes the raw PWM request is synchronous to i_clk.
`timescale 1ns/1ps
`default_nettype none
module mfs_pwm_shaper #(
  parameter int unsigned MIN_LOW = mfs_pkg::LS_MIN_ON_CYC
) (
  input wire logic i_clk, // System clock
  input wire logic i_rst, // Async reset, high
  input wire logic i_pwm, // Raw PWM request, high = high side on
  output logic o_pwm // Shaped PWM to the device
);
  import mfs_pkg::*;
  localparam int unsigned CW = $clog2(MIN_LOW + 1);
  logic [CW-1:0] low_cnt_q, low_cnt_d;
  logic pwm_q, pwm_d;

  always_comb begin
    low_cnt_d = low_cnt_q;
    pwm_d = pwm_q;
    if (!pwm_q) begin
      // Low side stays on long enough to top up the bootstrap cap
      if (low_cnt_q < CW'(MIN_LOW)) begin // R13
        low_cnt_d = low_cnt_q + CW'(1);
      end else if (i_pwm) begin
        pwm_d = 1'b1;
      end
    end else if (!i_pwm) begin
      pwm_d = 1'b0;
      low_cnt_d = CW'(1);
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      low_cnt_q <= '0;
      pwm_q <= 1'b0;
    end else begin
      low_cnt_q <= low_cnt_d;
      pwm_q <= pwm_d;
    end
  end

  assign o_pwm = pwm_q;
endmodule
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the controller with a behavioural power stage.
// Assumes a shortened hold-off so latched recovery stays brief.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import mfs_pkg::*;
  localparam int unsigned HOLD = 20;
  logic i_clk = 0, i_rst = 1, i_power_good = 0, i_enable = 1, i_recover = 0;
  logic [2:0] i_pwm = 3'h0, o_pwm, o_clear_n;
  logic uv = 0, oc = 0, hot = 0, warm = 0, fault_pull, warn_pull, o_reduce_load, o_running;
  wire logic i_fault_n, i_thermal_warning_n;
  mfs_status_t o_status;
  int n_fail = 0, checks_done = 0, seed = 32'h9487be37, t, code;
  assign i_fault_n = !fault_pull;
  assign i_thermal_warning_n = !warn_pull;
  mfs_ctrl #(.HOLDOFF_CYC(HOLD)) mfs_ctrl_i (.i_clk(i_clk), .i_rst(i_rst), .i_power_good(i_power_good),
    .i_enable(i_enable), .i_recover(i_recover), .i_pwm(i_pwm), .i_fault_n(i_fault_n),
    .i_thermal_warning_n(i_thermal_warning_n), .o_pwm(o_pwm), .o_clear_n(o_clear_n), .o_status(o_status),
    .o_reduce_load(o_reduce_load), .o_running(o_running));
  mfs_dev_model mfs_dev_model_i (.i_clk(i_clk), .i_clear_n(o_clear_n), .i_uv(uv), .i_oc(oc), .i_hot(hot),
    .i_warm(warm), .o_fault_pull(fault_pull), .o_warn_pull(warn_pull), .o_hiz());
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    if (n_fail == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic wait_run(input int lim);
    t = 0;
    while (o_running !== 1'b1 && t < lim) begin
      @(posedge i_clk);
      t++;
    end
    @(negedge i_clk);
    if (o_running !== 1'b1) begin
      n_fail++;
      finish_test();
    end
  endtask
  function automatic logic [1:0] exp_status(input logic f, input logic w);
    return f ? (w ? MFS_ST_NORMAL : MFS_ST_WARN) : (w ? MFS_ST_SHUTDOWN : MFS_ST_WARN_SHUTDOWN);
  endfunction
  initial forever #12.5 i_clk = ~i_clk;
  initial begin
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_clk);
    @(negedge i_clk) check(o_clear_n, 3'h0, "clear_n powerup");
    @(posedge i_clk) i_power_good <= 1'b1;
    wait_run(10);
    check(o_clear_n, 3'h7, "clear_n run");
    for (int k = 0; k < 40; k++) begin
      code = 1 + {$random(seed)} % 3;
      @(posedge i_clk) begin
        uv <= !code[1];
        warm <= !code[0];
      end
      repeat (3) @(posedge i_clk) i_pwm <= $random(seed);
      @(negedge i_clk);
      check(o_status, exp_status(code[1], code[0]), "status");
      check(o_reduce_load, !code[0], "reduce_load");
      check(o_running, code[1], "running");
      if (!code[1]) check(o_pwm, 3'h0, "pwm fault");
    end
    // Early recover request must be refused during hold-off
    @(posedge i_clk) begin
      uv <= 1'b0;
      hot <= 1'b1;
      warm <= 1'b1;
      i_recover <= 1'b1;
    end
    @(posedge i_clk) hot <= 1'b0;
    // Fault line drops on the edge that sets the latch, running one edge later
    @(posedge i_clk);
    @(negedge i_clk) check(o_running, 1'b0, "running hot");
    t = 0;
    while (o_clear_n !== 3'h0 && t < 3 * HOLD) begin
      @(posedge i_clk);
      t++;
    end
    check(t >= HOLD, 1'b1, "holdoff");
    @(posedge i_clk) warm <= 1'b0;
    wait_run(20);
    check(i_fault_n, 1'b1, "thermal cleared");
    @(posedge i_clk) begin
      oc <= 1'b1;
      i_recover <= 1'b0;
    end
    @(posedge i_clk) oc <= 1'b0;
    repeat (5) @(posedge i_clk);
    @(negedge i_clk) check(i_fault_n, 1'b0, "oc latched");
    @(posedge i_clk) i_recover <= 1'b1;
    wait_run(3 * HOLD);
    check(i_fault_n, 1'b1, "oc cleared");
    @(posedge i_clk) begin
      i_recover <= 1'b0;
      i_power_good <= 1'b0;
    end
    repeat (2) @(posedge i_clk);
    @(negedge i_clk) check(o_clear_n, 3'h0, "clear_n powerdown");
    finish_test();
  end
endmodule
`default_nettype wire
